// File: fblk_host.sv
// apb-controlled host that drives the flash bus: lock commands, program, erase, status poll
// What the device and this block do
// RL1 - set-lock locks unlocked or lockdown-disabled blocks
// RL2 - clear-lock unlocks except locked-down with pin low
// RL3 - lock-down on unlocked block also locks it
// RL4 - lock-down moves 001 to 011, 101 to 111
// RL5 - locked-down with pin low ignores lock commands
// RL6 - pin rising keeps lock bit, sets pin bit, except in 011 (RL7)
// RL7 - rising pin in 011 depends on origin
// RL8 - falling pin from 11x gives 011
// RL9 - falling pin from 10x keeps lock bit
// RL10 - status word reserved bits masked by host
// RL11 - bit 7 reports engine ready
// RL12 - bit 6 reports erase suspended
// RL13 - bit 5 reports erase error
// RL14 - bit 4 reports program error
// RL15 - bit 3 reports accelerator voltage abort
// RL16 - bit 2 reports program suspended
// RL17 - bit 1 reports locked-block abort
// RL18 - protect flag sampled only after operations
// RL19 - flags invalid while ready is low
// RL20 - both error bits mean bad sequence
// RL21 - host polls ready to detect completion
// RL22 - lock state read via identifier codes
// RL23 - reset leaves every block locked, not down
// RL24 - locked blocks refuse erase and program
// RL25 - lock state kept separately per block
`timescale 1ns/1ps
module fblk_host
    import fblk_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output fblk_bus_s        flashBus,
    input  wire logic [15:0] flashDqIn,
    input  wire logic        readyBusyPin,
    output logic             protectAccelPin,
    output logic             busy
);
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_WR1    = 4'b0001,
        S_WR2    = 4'b0010,
        S_POLLC  = 4'b0011,
        S_POLLR  = 4'b0100,
        S_IDC    = 4'b0101,
        S_IDR    = 4'b0110,
        S_ARRC   = 4'b0111,
        S_ARRR   = 4'b1000,
        S_GAP    = 4'b1001
    } fblk_st_e;

    fblk_st_e    st_r;
    logic [2:0]  op_r;
    logic [20:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] status_r;
    logic [15:0] rdata_r;
    logic [2:0]  lockState_r;
    logic [3:0]  cnt_r;
    logic        second_r;
    logic [15:0] dqSync;
    logic        rbSync;
    logic        wrEn;
    logic        go;

    fblk_sync #(.W(17)) u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      ({readyBusyPin, flashDqIn}),
        .dout     ({rbSync, dqSync})
    );

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn    = psel && penable && pwrite;
    assign go      = wrEn && paddr == REG_CTRL && pwdata[CTRL_GO_BIT] && st_r == S_IDLE;
    assign busy    = st_r != S_IDLE;

    // software registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_r          <= '0;
            wdata_r         <= '0;
            op_r            <= '0;
            protectAccelPin <= 1'b0;
        end else if (wrEn) begin
            case (paddr)
                REG_ADDR:  addr_r  <= pwdata[20:0];
                REG_WDATA: wdata_r <= pwdata[15:0];
                REG_CTRL: begin
                    protectAccelPin <= pwdata[CTRL_PIN_BIT]; // [RL6] [RL8] [RL9]
                    if (st_r == S_IDLE) op_r <= pwdata[CTRL_OP_LSB +: CTRL_OP_W];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        case (paddr)
            REG_CTRL:   prdata = {24'h0, 1'b0, op_r, 2'b0, protectAccelPin, busy};
            REG_ADDR:   prdata = {11'h0, addr_r};
            REG_WDATA:  prdata = {16'h0, wdata_r};
            REG_STATUS: prdata = {16'h0, status_r & SR_VALID_MASK}; // [RL10]
            REG_RDATA:  prdata = {16'h0, rdata_r};
            REG_LOCK:   prdata = {29'h0, lockState_r};               // [RL22]
            default:    prdata = 32'h0;
        endcase
    end

    function automatic logic [15:0] first_cmd(input logic [2:0] op);
        case (op)
            OP_PROGRAM:  return CMD_PROGRAM;
            OP_ERASE:    return CMD_ERASE;
            OP_CLR_SR:   return CMD_CLR_SR;
            OP_RD_LOCK:  return CMD_READ_ID;
            OP_RD_ARRAY: return CMD_READ_ARRAY;
            default:     return CMD_LOCK_SETUP;
        endcase
    endfunction : first_cmd

    function automatic logic [15:0] second_cmd(input logic [2:0] op, input logic [15:0] d);
        case (op)
            OP_SET_LOCK: return CMD_SET_LOCK; // [RL1]
            OP_CLR_LOCK: return CMD_CLR_LOCK; // [RL2]
            OP_SET_LKDN: return CMD_SET_LKDN; // [RL3] [RL4] [RL5]
            OP_PROGRAM:  return d;
            default:     return CMD_CONFIRM;
        endcase
    endfunction : second_cmd

    // bus sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r     <= S_IDLE;
            cnt_r    <= '0;
            second_r <= 1'b0;
            flashBus <= '{addr: '0, dqOut: '0, dqOe: 1'b0, ceN: 1'b1, oeN: 1'b1, weN: 1'b1};
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (go) begin
                        flashBus.addr  <= addr_r;
                        flashBus.dqOut <= first_cmd(pwdata[CTRL_OP_LSB +: CTRL_OP_W]);
                        flashBus.dqOe  <= 1'b1;
                        flashBus.ceN   <= 1'b0;
                        flashBus.weN   <= 1'b0;
                        cnt_r          <= 4'(WE_CYC);
                        second_r       <= 1'b0;
                        st_r           <= S_WR1;
                    end
                end
                S_WR1: begin
                    if (cnt_r > 4'd1) begin
                        cnt_r <= cnt_r - 4'd1;
                    end else begin
                        flashBus.weN <= 1'b1;
                        flashBus.ceN <= 1'b1;
                        st_r         <= S_WR2;
                    end
                end
                S_WR2: begin
                    if (!second_r && op_r != OP_CLR_SR && op_r != OP_RD_LOCK
                        && op_r != OP_RD_ARRAY) begin
                        flashBus.dqOut <= second_cmd(op_r, wdata_r);
                        flashBus.ceN   <= 1'b0;
                        flashBus.weN   <= 1'b0;
                        cnt_r          <= 4'(WE_CYC);
                        second_r       <= 1'b1;
                        st_r           <= S_WR1;
                    end else begin
                        flashBus.dqOe <= 1'b0;
                        st_r          <= S_GAP;
                    end
                end
                S_GAP: begin
                    flashBus.ceN <= 1'b0;
                    flashBus.oeN <= 1'b0;
                    cnt_r        <= 4'(RD_CYC + 3);
                    if (op_r == OP_RD_LOCK) begin
                        flashBus.addr <= addr_r | LOCK_CODE_OFS; // [RL22]
                        st_r          <= S_IDC;
                    end else if (op_r == OP_RD_ARRAY) begin
                        st_r <= S_ARRC;
                    end else if (op_r == OP_CLR_SR) begin
                        flashBus.ceN <= 1'b1;
                        flashBus.oeN <= 1'b1;
                        st_r         <= S_IDLE;
                    end else begin
                        st_r <= S_POLLC;
                    end
                end
                S_POLLC, S_IDC, S_ARRC: begin
                    if (cnt_r > 4'd1) begin
                        cnt_r <= cnt_r - 4'd1;
                    end else begin
                        st_r <= (st_r == S_POLLC) ? S_POLLR : (st_r == S_IDC) ? S_IDR : S_ARRR;
                    end
                end
                S_POLLR: begin
                    // completion only by status bit 7 with the busy pin released
                    if (dqSync[SR_READY] && rbSync) begin // [RL21] [RL11]
                        flashBus.ceN <= 1'b1;
                        flashBus.oeN <= 1'b1;
                        st_r         <= S_IDLE;
                    end else begin
                        cnt_r <= 4'(RD_CYC + 3);
                        st_r  <= S_POLLC;
                    end
                end
                S_IDR, S_ARRR: begin
                    flashBus.ceN <= 1'b1;
                    flashBus.oeN <= 1'b1;
                    st_r         <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // captured status; flags are invalid while busy, so they read as zero until ready
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            status_r <= '0;
        end else if (st_r == S_POLLR) begin
            status_r <= dqSync[SR_READY] ? (dqSync & SR_VALID_MASK) : 16'h0; // [RL11] [RL19]
            // [RL12] [RL13] [RL14] [RL15] [RL16] [RL17] [RL18] [RL20]
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r     <= '0;
            lockState_r <= '0;
        end else if (st_r == S_IDR) begin
            lockState_r <= fblk_state(protectAccelPin, dqSync); // [RL22] [RL25]
        end else if (st_r == S_ARRR) begin
            rdata_r <= dqSync;
        end
    end

    property p_write_pulse;
        @(posedge core_clk) disable iff (sys_rst)
        $fell(flashBus.weN) |-> !flashBus.ceN && flashBus.dqOe [*2];
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write pulse not framed"); // [RL1]

    property p_flags_ready;
        @(posedge core_clk) disable iff (sys_rst)
        (status_r & SR_FLAGS_MASK) != 16'h0 |-> status_r[SR_READY];
    endproperty
    a_flags_ready: assert property (p_flags_ready) else $error("flags held while busy"); // [RL19]

    property p_reserved;
        @(posedge core_clk) disable iff (sys_rst) (status_r & ~SR_VALID_MASK) == 16'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bits set"); // [RL10]

    property p_poll_done;
        @(posedge core_clk) disable iff (sys_rst)
        st_r == S_POLLR && dqSync[SR_READY] && rbSync |=> st_r == S_IDLE && status_r[SR_READY];
    endproperty
    a_poll_done: assert property (p_poll_done) else $error("ready not accepted"); // [RL21]

    property p_no_oe_clash;
        @(posedge core_clk) disable iff (sys_rst) !(flashBus.dqOe && !flashBus.oeN);
    endproperty
    a_no_oe_clash: assert property (p_no_oe_clash) else $error("bus contention"); // [RL11]

    property p_busy_poll;
        @(posedge core_clk) disable iff (sys_rst)
        st_r == S_POLLR && !dqSync[SR_READY] |=> st_r == S_POLLC;
    endproperty
    a_busy_poll: assert property (p_busy_poll) else $error("left poll while busy"); // [RL11]

    property p_lock_capture;
        @(posedge core_clk) disable iff (sys_rst)
        st_r == S_IDR |=> lockState_r == fblk_state($past(protectAccelPin), $past(dqSync));
    endproperty
    a_lock_capture: assert property (p_lock_capture) else $error("lock code lost"); // [RL22]

    property p_go_starts;
        @(posedge core_clk) disable iff (sys_rst) go |=> st_r == S_WR1 && !flashBus.weN;
    endproperty
    a_go_starts: assert property (p_go_starts) else $error("command not started"); // [RL1]

    c_lock:  cover property (@(posedge core_clk) st_r == S_IDR);
    c_poll:  cover property (@(posedge core_clk) st_r == S_POLLR && dqSync[SR_READY]);
    c_error: cover property (@(posedge core_clk) status_r[SR_ERS_ERR] && status_r[SR_PRG_ERR]);
endmodule : fblk_host

// File: fblk_pkg.sv
// package: register map, command codes, lock-state and status-word layout for the flash host
package fblk_pkg;
    // host register word offsets (byte addresses on apb)
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    localparam logic [7:0] REG_LOCK   = 8'h14;

    // ctrl register fields
    localparam int CTRL_GO_BIT  = 0;
    localparam int CTRL_PIN_BIT = 1;
    localparam int CTRL_OP_LSB  = 4;
    localparam int CTRL_OP_W    = 3;

    // status word bit positions
    localparam int SR_READY     = 7;
    localparam int SR_ERS_SUSP  = 6;
    localparam int SR_ERS_ERR   = 5;
    localparam int SR_PRG_ERR   = 4;
    localparam int SR_ACC_ABORT = 3;
    localparam int SR_PRG_SUSP  = 2;
    localparam int SR_PROT_ABT  = 1;
    localparam logic [15:0] SR_VALID_MASK = 16'h00fe;
    localparam logic [15:0] SR_FLAGS_MASK = 16'h007e;

    // device command codes
    localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
    localparam logic [15:0] CMD_READ_ID    = 16'h0090;
    localparam logic [15:0] CMD_READ_SR    = 16'h0070;
    localparam logic [15:0] CMD_CLR_SR     = 16'h0050;
    localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
    localparam logic [15:0] CMD_SET_LOCK   = 16'h0001;
    localparam logic [15:0] CMD_CLR_LOCK   = 16'h00d0;
    localparam logic [15:0] CMD_SET_LKDN   = 16'h002f;
    localparam logic [15:0] CMD_PROGRAM    = 16'h0040;
    localparam logic [15:0] CMD_ERASE      = 16'h0020;
    localparam logic [15:0] CMD_CONFIRM    = 16'h00d0;
    localparam logic [20:0] LOCK_CODE_OFS  = 21'h000002;

    // host operations requested by software
    typedef enum logic [2:0] {
        OP_SET_LOCK = 3'b000,
        OP_CLR_LOCK = 3'b001,
        OP_SET_LKDN = 3'b010,
        OP_PROGRAM  = 3'b011,
        OP_ERASE    = 3'b100,
        OP_RD_LOCK  = 3'b101,
        OP_RD_ARRAY = 3'b110,
        OP_CLR_SR   = 3'b111
    } fblk_op_e;

    // bus cycle timing in core clocks
    localparam int  T_WE_NS    = 70;
    localparam int  T_RD_NS    = 100;
    localparam int  CLK_NS     = 50;
    localparam int  WE_CYC     = (T_WE_NS + CLK_NS - 1) / CLK_NS;
    localparam int  RD_CYC     = (T_RD_NS + CLK_NS - 1) / CLK_NS;

    // flash bus pins
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dqOut;
        logic        dqOe;
        logic        ceN;
        logic        oeN;
        logic        weN;
    } fblk_bus_s;

    // three-bit lock state: pin level, lock-down, lock
    function automatic logic [2:0] fblk_state(input logic pin, input logic [15:0] code);
        return {pin, code[1], code[0]};
    endfunction : fblk_state
endpackage : fblk_pkg

// File: fblk_sync.sv
// three-stage input synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ps
module fblk_sync
    import fblk_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    initial begin
        if (W < 1) $error("fblk_sync width must be positive");
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    dout[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : fblk_sync

// File: fblk_dev_model.sv
// behavioural flash device: per-block lock states, status word and ready/busy pin
`timescale 1ns/1ps
module fblk_dev_model
    import fblk_pkg::*;
#(
    parameter int BLK_SH = 15
) (
    input  wire fblk_bus_s   bus,
    input  wire logic        protectAccelPin,
    input  wire logic        slow,
    output logic      [15:0] flashDqIn,
    output logic             readyBusyPin
);
    logic [63:0] lockBit, downBit, fromDis;
    logic [15:0] mem [int];
    logic [6:1]  sr;
    logic [15:0] seqCmd, lastQ, rdVal, latD, pendD;
    logic [20:0] latA, pendA;
    logic [1:0]  mode;
    logic        prevPin, protFail, isPrg;
    int          blk;
    wire         wrAct = !bus.ceN && !bus.weN;
    wire         drv = !bus.ceN && !bus.oeN;

    initial begin
        lockBit = '1;
        downBit = '0;
        fromDis = '0;
        sr = '0;
        seqCmd = '0;
        lastQ = '0;
        mode = 2'd0;
        prevPin = 1'b0;
        readyBusyPin = 1'b1;
    end

    always @* begin
        if (wrAct) begin
            latA = bus.addr;
            latD = bus.dqOut;
        end
    end

    // a command word takes effect when write enable or chip enable rises
    always @(negedge wrAct) begin
        blk = int'(latA >> BLK_SH);
        if (seqCmd == CMD_LOCK_SETUP) begin
            mode = 2'd2;
            if (!downBit[blk] || protectAccelPin) begin
                case (latD)
                    CMD_SET_LOCK: lockBit[blk] = 1'b1;
                    CMD_CLR_LOCK: lockBit[blk] = 1'b0;
                    CMD_SET_LKDN: begin
                        lockBit[blk] = 1'b1;
                        downBit[blk] = 1'b1;
                        fromDis[blk] = 1'b0;
                    end
                    default: sr[5:4] = 2'b11;
                endcase
            end
        end else if (seqCmd == CMD_PROGRAM || seqCmd == CMD_ERASE) begin
            mode = 2'd2;
            isPrg = (seqCmd == CMD_PROGRAM);
            pendA = latA;
            pendD = latD;
            protFail = lockBit[blk];
            readyBusyPin = 1'b0;
        end else begin
            case (latD)
                CMD_READ_ARRAY: mode = 2'd0;
                CMD_READ_ID: mode = 2'd1;
                CMD_READ_SR: mode = 2'd2;
                CMD_CLR_SR: sr = '0;
                default: ;
            endcase
        end
        seqCmd = (seqCmd == 16'h0 && latD inside {CMD_LOCK_SETUP, CMD_PROGRAM, CMD_ERASE})
            ? latD : 16'h0;
    end

    // erase and program never fail here, so their error bits rise only on bad sequences
    always @(negedge readyBusyPin) begin
        #(slow ? 3000 : 200);
        sr[1] = protFail;
        if (!protFail && isPrg) begin
            mem[int'(pendA)] = pendD;
        end
        readyBusyPin = 1'b1;
    end

    always @(protectAccelPin) begin
        for (int i = 0; i < 64; i++) begin
            if (protectAccelPin === 1'b1 && prevPin === 1'b0 && downBit[i]) begin
                lockBit[i] = !fromDis[i];
            end
            if (protectAccelPin === 1'b0 && prevPin === 1'b1 && downBit[i]) begin
                fromDis[i] = !lockBit[i];
                lockBit[i] = 1'b1;
            end
        end
        prevPin = protectAccelPin;
    end

    // no suspend or high-voltage path exists, so bits 6, 3 and 2 read clear once ready; while busy the inverted word shows them set
    always @* begin
        case (mode)
            2'd0: rdVal = mem.exists(int'(bus.addr)) ? mem[int'(bus.addr)] : 16'hffff;
            2'd1: rdVal = (bus.addr[BLK_SH-1:0] == LOCK_CODE_OFS[BLK_SH-1:0])
                ? {14'h0, downBit[bus.addr[20:BLK_SH]], lockBit[bus.addr[20:BLK_SH]]} : 16'h0;
            default: rdVal = {8'h00, readyBusyPin, readyBusyPin ? sr : ~sr, 1'b0};
        endcase
    end

    always @* begin
        if (drv) begin
            lastQ = rdVal;
        end
    end
    // released data lines show the inverse of the last value
    assign flashDqIn = bus.dqOe ? bus.dqOut : (drv ? rdVal : ~lastQ);
endmodule : fblk_dev_model

// File: test_fblk_host.sv
// self-checking bench: apb tasks drive lock, program, erase and status sequences
`timescale 1ns/1ps
module test_fblk_host
    import fblk_pkg::*;
;
    localparam logic [20:0] BLK_A = 21'h000000;
    localparam logic [20:0] BLK_B = 21'h008000;
    localparam logic [20:0] BLK_C = 21'h010000;
    logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    fblk_bus_s   flashBus;
    logic [15:0] flashDqIn;
    logic        readyBusyPin, protectAccelPin, busy, slow, pin;
    int          nFail, totalChecks;
    fblk_op_e    lockOps [3] = '{OP_SET_LOCK, OP_CLR_LOCK, OP_SET_LKDN};

    fblk_host dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flashBus(flashBus), .flashDqIn(flashDqIn),
        .readyBusyPin(readyBusyPin), .protectAccelPin(protectAccelPin), .busy(busy)
    );
    fblk_dev_model dev_u (
        .bus(flashBus), .protectAccelPin(protectAccelPin), .slow(slow),
        .flashDqIn(flashDqIn), .readyBusyPin(readyBusyPin)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] expV, input logic [31:0] got);
        totalChecks++;
        if (got !== expV) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, expV, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        chk("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic doOp(input fblk_op_e op, input logic [20:0] a, input logic [15:0] d);
        int n;
        apb(1'b1, REG_ADDR, {11'h000, a});
        apb(1'b1, REG_WDATA, {16'h0000, d});
        apb(1'b1, REG_CTRL, {25'h0, op, 2'b00, pin, 1'b1});
        chk("busy pin", 32'h1, {31'h0, busy});
        rd = 32'h1;
        for (n = 0; rd[CTRL_GO_BIT] !== 1'b0 && n < 500; n++) apb(1'b0, REG_CTRL, 32'h0);
        chk("busy pin", 32'h0, {31'h0, busy});
    endtask : doOp

    task automatic lockIs(input logic [20:0] a, input logic [2:0] expV);
        doOp(OP_RD_LOCK, a, 16'h0);
        apb(1'b0, REG_LOCK, 32'h0);
        chk("lock state", {29'h0, expV}, rd);
    endtask : lockIs

    task automatic stIs(input logic [31:0] expV);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status word", expV, rd);
    endtask : stIs

    task automatic setPin(input logic p);
        pin = p;
        apb(1'b1, REG_CTRL, {30'h0, p, 1'b0});
    endtask : setPin

    task automatic end_sim();
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        #2000000;
        nFail++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, slow, pin} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        nFail = 0;
        totalChecks = 0;
        sys_rst = 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        apb(1'b1, 8'h1c, 32'hffffffff);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped word", 32'h0, rd);
        lockIs(BLK_A, 3'b001);
        doOp(OP_CLR_LOCK, BLK_A, 16'h0);
        lockIs(BLK_A, 3'b000);
        lockIs(BLK_B, 3'b001);
        slow = 1'b1;
        doOp(OP_PROGRAM, BLK_A + 21'h5, 16'h5a3c);
        stIs(32'h80);
        doOp(OP_RD_ARRAY, BLK_A + 21'h5, 16'h0);
        apb(1'b0, REG_RDATA, 32'h0);
        chk("array word", 32'h5a3c, rd);
        slow = 1'b0;
        doOp(OP_PROGRAM, BLK_B, 16'h1234);
        stIs(32'h82);
        doOp(OP_CLR_SR, BLK_A, 16'h0);
        stIs(32'h82);
        doOp(OP_SET_LKDN, BLK_A, 16'h0);
        stIs(32'h80);
        lockIs(BLK_A, 3'b011);
        doOp(OP_SET_LKDN, BLK_C, 16'h0);
        lockIs(BLK_C, 3'b011);
        foreach (lockOps[i]) begin
            doOp(lockOps[i], BLK_A, 16'h0);
            lockIs(BLK_A, 3'b011);
        end
        setPin(1'b1);
        lockIs(BLK_A, 3'b111);
        lockIs(BLK_B, 3'b101);
        doOp(OP_CLR_LOCK, BLK_A, 16'h0);
        lockIs(BLK_A, 3'b110);
        doOp(OP_CLR_LOCK, BLK_B, 16'h0);
        setPin(1'b0);
        lockIs(BLK_A, 3'b011);
        lockIs(BLK_B, 3'b000);
        setPin(1'b1);
        lockIs(BLK_A, 3'b110);
        doOp(OP_SET_LOCK, BLK_A, 16'h0);
        lockIs(BLK_A, 3'b111);
        doOp(OP_ERASE, BLK_A, 16'h0);
        stIs(32'h82);
        slow = 1'b1;
        doOp(OP_ERASE, BLK_B, 16'h0);
        stIs(32'h80);
        end_sim();
    end
endmodule : test_fblk_host
